// ---- include/lob_defines.svh ----
`ifndef LOB_DEFINES_SVH
`define LOB_DEFINES_SVH

// Register byte addresses on the control bus.
`define LOB_CTRL_ADDR 8'h00
`define LOB_STATUS_ADDR 8'h04
`define LOB_RESULT_ADDR 8'h08
`define LOB_PC_ADDR 8'h0C
`define LOB_COUNT_ADDR 8'h10

// Control register fields and reset value.
`define LOB_CTRL_EN_BIT 0
`define LOB_CTRL_RESET 32'h0000_0001

// Status register fields.
`define LOB_STAT_CC_LSB 0
`define LOB_STAT_TAKEN_BIT 4
`define LOB_STAT_WE_BIT 5

// Condition code positions inside a four-bit code.
`define LOB_CC_N 3
`define LOB_CC_Z 2
`define LOB_CC_V 1
`define LOB_CC_C 0

// Bus answers.
`define LOB_RESP_OKAY 2'h0
`define LOB_RESP_SLVERR 2'h2

// Branch reach in words: 200 octal back, 177 octal forward.
`define LOB_BACK_WORDS 16'h0080
`define LOB_FWD_WORDS 16'h007F

`endif

// ---- include/lob_pkg.sv ----
package lob_pkg;

	// Operations issued by the decoder.
	typedef enum logic [3:0] {
		op_none,
		bit_test_op,
		bit_test_byte_op,
		bit_clear_op,
		bit_clear_byte_op,
		bit_set_op,
		bit_set_byte_op,
		xor_op,
		branch_op
	} lob_op_t;

	// Request from decoder, register file and sequencer.
	typedef struct packed {
		lob_op_t op;
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] pc;
		logic [7:0] offset;
		logic [3:0] cc;
		logic uncond;
		logic cond_met;
	} lob_req_t;

	// Answer to the sequencer, one cycle after the request.
	typedef struct packed {
		logic valid;
		logic [15:0] result;
		logic dst_we;
		logic [3:0] cc;
		logic [15:0] pc;
		logic taken;
	} lob_rsp_t;

endpackage

// ---- src/lob_unit.sv ----
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lob_defines.svh"

module lob_unit
	import lob_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire lob_req_t req,
	output logic req_ready,
	output lob_rsp_t rsp,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	////////////////////////////////////////////////////////////////////////
	// Shared arithmetic.

	// Word offset to byte displacement with the sign carried up.
	function automatic logic [15:0] branch_disp(input logic [7:0] off);
		branch_disp = {{7{off[7]}}, off, 1'b0};
	endfunction

	// Codes for the logical group; carry is passed through untouched.
	function automatic logic [3:0] logic_cc(input logic [15:0] r,
			input logic is_byte, input logic c_in);
		logic n;
		logic z;
		n = is_byte ? r[7] : r[15];
		z = is_byte ? (r[7:0] == 8'h00) : (r == 16'h0000);
		logic_cc = {n, z, 1'b0, c_in};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Datapath.

	logic ctrl_en;
	logic [31:0] op_count;
	logic [31:0] next_op_count;
	lob_rsp_t next_rsp;
	logic req_fire;
	logic [15:0] lo_res;

	assign req_fire = req_valid & req_ready;

	// One answer per accepted request; the sequencer owns the
	// program counter advance, so logical ops hand back the pc as is.
	always_comb begin
		next_rsp = rsp;
		next_rsp.valid = 1'b0;
		next_op_count = op_count;
		lo_res = 16'h0000;
		if (req_fire) begin
			next_op_count = op_count + 32'h0000_0001;
			next_rsp.valid = 1'b1;
			next_rsp.result = req.dst;
			next_rsp.dst_we = 1'b0;
			next_rsp.cc = req.cc;
			next_rsp.pc = req.pc;
			next_rsp.taken = 1'b0;
			case (req.op)
				bit_test_op, bit_test_byte_op: begin
					lo_res = req.src & req.dst;
					next_rsp.result = lo_res;
					next_rsp.cc = logic_cc(lo_res,
						req.op == bit_test_byte_op, req.cc[`LOB_CC_C]);
				end
				bit_clear_op, bit_clear_byte_op: begin
					lo_res = ~req.src & req.dst;
					next_rsp.dst_we = 1'b1;
					next_rsp.cc = logic_cc(lo_res,
						req.op == bit_clear_byte_op, req.cc[`LOB_CC_C]);
					next_rsp.result = (req.op == bit_clear_byte_op) ?
						{req.dst[15:8], lo_res[7:0]} : lo_res;
				end
				bit_set_op, bit_set_byte_op: begin
					lo_res = req.src | req.dst;
					next_rsp.dst_we = 1'b1;
					next_rsp.cc = logic_cc(lo_res,
						req.op == bit_set_byte_op, req.cc[`LOB_CC_C]);
					next_rsp.result = (req.op == bit_set_byte_op) ?
						{req.dst[15:8], lo_res[7:0]} : lo_res;
				end
				xor_op: begin
					lo_res = req.src ^ req.dst;
					next_rsp.result = lo_res;
					next_rsp.dst_we = 1'b1;
					next_rsp.cc = logic_cc(lo_res, 1'b0, req.cc[`LOB_CC_C]);
				end
				branch_op: begin
					// Codes pass through unchanged in both outcomes.
					next_rsp.taken = req.uncond | req.cond_met;
					next_rsp.cc = req.cc;
					if (next_rsp.taken) begin
						next_rsp.pc = req.pc + branch_disp(req.offset);
					end
				end
				default: next_rsp.result = req.dst;
			endcase
		end
	end

	// Answer register.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp <= '0;
			op_count <= 32'h0000_0000;
		end else begin
			rsp <= next_rsp;
			op_count <= next_op_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_ctrl_en;
	logic next_req_ready, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;

	// Address and data are taken in either order; the write lands once
	// both are held, and nothing more is taken until the answer leaves.
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_ctrl_en = ctrl_en;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `LOB_RESP_OKAY;
			case (aw_addr)
				`LOB_CTRL_ADDR: begin
					if (w_strb[0]) begin
						next_ctrl_en = w_data[`LOB_CTRL_EN_BIT];
					end
				end
				`LOB_STATUS_ADDR, `LOB_RESULT_ADDR, `LOB_PC_ADDR,
				`LOB_COUNT_ADDR: begin
					next_bresp = `LOB_RESP_OKAY;
				end
				default: begin
					next_bresp = `LOB_RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_req_ready = next_ctrl_en;
	end

	// Write side registers.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LOB_RESP_OKAY;
			ctrl_en <= 1'(`LOB_CTRL_RESET >> `LOB_CTRL_EN_BIT);
			req_ready <= 1'(`LOB_CTRL_RESET >> `LOB_CTRL_EN_BIT);
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			ctrl_en <= next_ctrl_en;
			req_ready <= next_req_ready;
		end
	end

	// Reads answer one cycle after the address is taken.
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `LOB_RESP_OKAY;
			next_rdata = 32'h0000_0000;
			case (s_axi_araddr)
				`LOB_CTRL_ADDR: next_rdata[`LOB_CTRL_EN_BIT] = ctrl_en;
				`LOB_STATUS_ADDR: begin
					next_rdata[`LOB_STAT_CC_LSB +: 4] = rsp.cc;
					next_rdata[`LOB_STAT_TAKEN_BIT] = rsp.taken;
					next_rdata[`LOB_STAT_WE_BIT] = rsp.dst_we;
				end
				`LOB_RESULT_ADDR: next_rdata[15:0] = rsp.result;
				`LOB_PC_ADDR: next_rdata[15:0] = rsp.pc;
				`LOB_COUNT_ADDR: next_rdata = op_count;
				default: next_rresp = `LOB_RESP_SLVERR;
			endcase
		end
		next_arready = !next_rvalid;
	end

	// Read side registers.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LOB_RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the answer path.

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	bit_test_nowrite_a: assert property (
		req_fire && req.op == bit_test_op |=> rsp.valid && !rsp.dst_we
		&& rsp.result == ($past(req.src) & $past(req.dst)))
		else $error("bit test wrote or gave wrong value");
	logic_codes_a: assert property (
		req_fire && (req.op == bit_clear_op || req.op == bit_set_op)
		|=> !rsp.cc[`LOB_CC_V] && rsp.cc[`LOB_CC_C] == $past(req.cc[0])
		&& rsp.cc[`LOB_CC_N] == rsp.result[15]
		&& rsp.cc[`LOB_CC_Z] == (rsp.result == 16'h0000))
		else $error("logical codes wrong");
	bit_clear_value_a: assert property (
		req_fire && req.op == bit_clear_op |=> rsp.dst_we
		&& rsp.result == (~$past(req.src) & $past(req.dst)))
		else $error("bit clear value wrong");
	bit_set_value_a: assert property (
		req_fire && req.op == bit_set_op |=> rsp.dst_we
		&& rsp.result == ($past(req.src) | $past(req.dst)))
		else $error("bit set value wrong");
	xor_value_a: assert property (
		req_fire && req.op == xor_op |=> rsp.dst_we && !rsp.cc[1]
		&& rsp.result == ($past(req.src) ^ $past(req.dst))
		&& rsp.cc[`LOB_CC_C] == $past(req.cc[0]))
		else $error("xor value or codes wrong");
	branch_taken_a: assert property (
		req_fire && req.op == branch_op |=> rsp.valid
		&& rsp.taken == ($past(req.uncond) || $past(req.cond_met)))
		else $error("branch decision wrong");
	branch_target_a: assert property (
		req_fire && req.op == branch_op && req.uncond |=> rsp.pc ==
		$past(req.pc) + {{7{$past(req.offset[7])}}, $past(req.offset), 1'b0})
		else $error("branch target wrong");
	branch_reach_a: assert property (
		req_fire && req.op == branch_op && req.uncond && req.offset[7]
		|=> 16'($past(req.pc) - rsp.pc) <= {`LOB_BACK_WORDS, 1'b0}
		&& rsp.pc != $past(req.pc))
		else $error("backward branch out of reach");
	not_taken_nop_a: assert property (
		req_fire && req.op == branch_op && !req.uncond && !req.cond_met
		|=> rsp.pc == $past(req.pc) && !rsp.dst_we && !rsp.taken)
		else $error("failed branch changed state");
	branch_cc_keep_a: assert property (
		req_fire && req.op == branch_op |=> rsp.cc == $past(req.cc))
		else $error("branch changed codes");
	byte_flags_a: assert property (
		req_fire && req.op == bit_set_byte_op |=>
		rsp.cc[`LOB_CC_N] == rsp.result[7]
		&& rsp.cc[`LOB_CC_Z] == (rsp.result[7:0] == 8'h00)
		&& rsp.result[15:8] == $past(req.dst[15:8]))
		else $error("byte codes wrong");

endmodule

// ---- verification/lob_partner.sv ----
`timescale 1ns/1ps

// Decoder model: it offers one request and holds it until the unit takes it.
// Once taken with no new request behind it, the request lines flip to their own inverse on each cycle the unit is ready, so a unit
// that samples stale operands gets garbage on alternate cycles rather than a steady lucky match.
module lob_partner
	import lob_pkg::*;
(
	input wire logic sys_clk,
	input wire logic go,
	input wire lob_req_t want,
	input wire logic req_ready,
	output logic req_valid,
	output lob_req_t req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end

	// A new request is loaded only when no earlier one is still pending.
	always @(posedge sys_clk) begin
		if (go && (!req_valid || req_ready)) begin
			req_valid <= 1'b1;
			req <= want;
		end else if (req_ready) begin
			req_valid <= 1'b0;
			req <= ~req;
		end
	end
endmodule

// ---- verification/test_logic_ops_branch_unit.sv ----
`timescale 1ns/1ps
`include "lob_defines.svh"

module test_logic_ops_branch_unit
	import lob_pkg::*;
;
	typedef struct packed {
		lob_rsp_t r;
		logic [1:0] m;
	} lob_note_t;
	logic sys_clk, rst_n, go, req_valid, req_ready;
	lob_req_t want, req;
	lob_rsp_t rsp;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [31:0] seed = 32'h0001_1290;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0] offs [4] = '{8'h80, 8'h7F, 8'hFF, 8'h00};
	lob_note_t exq[$];
	int miscompares, num_checks, n_req;

	lob_partner part_u (.sys_clk(sys_clk), .go(go), .want(want),
		.req_ready(req_ready), .req_valid(req_valid), .req(req));

	lob_unit dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	////////////////////////////////////////////////////////////////////////
	// Clock, random source and expected answers.
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Field m marks what is defined: bit 0 the result, bit 1 the taken flag.
	function automatic lob_note_t model(lob_req_t q);
		lob_note_t e;
		logic [15:0] r;
		logic b;
		e = '0;
		e.r.valid = 1'b1;
		e.r.pc = q.pc;
		e.r.cc = q.cc;
		b = q.op inside {bit_test_byte_op, bit_clear_byte_op, bit_set_byte_op};
		r = q.dst;
		case (q.op)
			bit_test_op, bit_test_byte_op: r = q.src & q.dst;
			bit_clear_op, bit_clear_byte_op: r = q.dst & ~q.src;
			bit_set_op, bit_set_byte_op: r = q.dst | q.src;
			xor_op: r = q.dst ^ q.src;
			default: ;
		endcase
		if (b && q.op != bit_test_byte_op) r[15:8] = q.dst[15:8];
		if (q.op == branch_op) begin
			e.m = 2'h2;
			e.r.taken = q.uncond | q.cond_met;
			if (e.r.taken) e.r.pc = q.pc + {{7{q.offset[7]}}, q.offset, 1'b0};
		end else if (q.op != op_none) begin
			e.m = 2'h1;
			e.r.result = r;
			e.r.dst_we = q.op != bit_test_op && q.op != bit_test_byte_op;
			e.r.cc = {b ? r[7] : r[15], b ? r[7:0] == 8'h00 : r == 16'h0000,
				1'b0, q.cc[0]};
		end
		return e;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Compare tasks and the verdict.
	task automatic chk32(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask

	task automatic chk_rsp(input lob_note_t e, input lob_rsp_t g);
		lob_rsp_t t;
		t = g;
		if (!e.m[0]) t.result = e.r.result;
		if (!e.m[1]) t.taken = e.r.taken;
		num_checks++;
		if (t !== e.r) begin
			miscompares++;
			$display("ERROR %0t exp %h got %h", $time, e.r, g);
		end
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// An answer with no pending note is compared to zero and so fails.
	always @(negedge sys_clk) begin
		if (rsp.valid === 1'b1)
			chk_rsp(exq.size() > 0 ? exq.pop_front() : '0, rsp);
	end

	////////////////////////////////////////////////////////////////////////
	// Drivers for the decoder side and the register bus.
	task automatic issue(input lob_req_t q);
		want <= q;
		go <= 1'b1;
		exq.push_back(model(q));
		n_req++;
		@(posedge sys_clk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w, b;
		{aw, w, b} = 3'b110;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w || !b) begin
			@(posedge sys_clk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (!b && s_axi_bvalid === 1'b1) begin
				b = 1'b1;
				s_axi_bready <= 1'b0;
				chk32(32'(er), 32'(s_axi_bresp));
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk32(ed, s_axi_rdata);
		chk32(32'(er), 32'(s_axi_rresp));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence; operations run back to back to stress the pipeline.
	initial begin
		lob_req_t q;
		{rst_n, go, want} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axi_rd(`LOB_CTRL_ADDR, `LOB_CTRL_RESET, `LOB_RESP_OKAY);
		axi_rd(`LOB_COUNT_ADDR, 32'h0, `LOB_RESP_OKAY);
		axi_rd(8'h14, 32'h0, `LOB_RESP_SLVERR);
		axi_wr(8'h18, 32'hFFFF_FFFF, `LOB_RESP_SLVERR);
		// Without the low strobe the enable bit must keep its value.
		s_axi_wstrb <= 4'hE;
		axi_wr(`LOB_CTRL_ADDR, 32'h0, `LOB_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(`LOB_CTRL_ADDR, `LOB_CTRL_RESET, `LOB_RESP_OKAY);
		for (int i = 0; i < 64; i++) begin
			q = lob_req_t'(66'({rnd(), rnd(), rnd()}));
			q.op = lob_op_t'(4'(rnd() % 9));
			issue(q);
		end
		for (int i = 0; i < 8; i++) begin
			q = '0;
			q.op = branch_op;
			q.pc = i < 4 ? 16'h0500 : 16'h0000;
			q.offset = offs[i % 4];
			q.uncond = i < 4;
			q.cond_met = i[0];
			q.cc = 4'(i + 5);
			issue(q);
		end
		q = '0;
		q.op = xor_op;
		q.src = 16'h029C;
		q.dst = 16'h0249;
		q.cc = 4'hF;
		issue(q);
		go <= 1'b0;
		repeat (3) @(posedge sys_clk);
		axi_rd(`LOB_RESULT_ADDR, 32'h00D5, `LOB_RESP_OKAY);
		axi_wr(`LOB_RESULT_ADDR, 32'h1234, `LOB_RESP_OKAY);
		axi_rd(`LOB_RESULT_ADDR, 32'h00D5, `LOB_RESP_OKAY);
		axi_rd(`LOB_COUNT_ADDR, 32'(n_req), `LOB_RESP_OKAY);
		// A disabled unit must leave the request pending and unanswered.
		axi_wr(`LOB_CTRL_ADDR, 32'h0, `LOB_RESP_OKAY);
		q.op = bit_set_op;
		issue(q);
		go <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk32(32'h1, 32'(exq.size()));
		axi_wr(`LOB_CTRL_ADDR, 32'h1, `LOB_RESP_OKAY);
		repeat (4) @(posedge sys_clk);
		chk32(32'h0, 32'(exq.size()));
		give_verdict();
	end

	// Watchdog: far beyond the hundred-odd cycles the sequence needs.
	initial begin
		#(50 * 20000);
		miscompares++;
		give_verdict();
	end
endmodule
